/* core/fpled_pkg.sv */
package fpled_pkg;

    // ==========================================================
    // ribbon layout, top to bottom
    // ==========================================================
    localparam int          RIB_N       = 13;
    localparam logic [3:0]  POS_PF      = 4'h0;
    localparam logic [3:0]  POS_THD     = 4'h1;
    localparam logic [3:0]  POS_VOLT    = 4'h2;
    localparam logic [3:0]  POS_CURR    = 4'h3;
    localparam logic [3:0]  POS_MISSQ   = 4'h4;
    localparam logic [3:0]  POS_INFO    = 4'h5;
    localparam logic [3:0]  POS_MAN     = 4'h6;
    localparam logic [3:0]  POS_SET     = 4'h7;
    localparam logic [3:0]  POS_RED0    = 4'h8;
    localparam logic [3:0]  POS_LAST    = 4'hC;
    localparam int          GRP_N       = 7;
    localparam int          GRP_LED_N   = 5;
    localparam int          ALM_PER     = 4;
    localparam int          ALM_N       = GRP_N * ALM_PER;
    localparam int          STEP_N      = 8;

    // ==========================================================
    // timing
    // ==========================================================
    localparam int          CLK_HZ      = 200_000_000;
    localparam int          TICK_MS     = 100;
    localparam int          TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
    localparam int          REFUSE_MS   = 3000;
    localparam int          REFUSE_TICKS = REFUSE_MS / TICK_MS;
    localparam longint      SW_FAULT_S  = 900;
    localparam longint      SW_FAULT_CYC = longint'(CLK_HZ) * SW_FAULT_S;
    localparam logic [1:0]  INIT_LOAD   = 2'h2;

    // ==========================================================
    // parameter slots, limits and defaults
    // ==========================================================
    localparam logic [2:0]  PAR_PF      = 3'h0;
    localparam logic [2:0]  PAR_THD     = 3'h1;
    localparam logic [2:0]  PAR_VTR     = 3'h2;
    localparam logic [2:0]  PAR_UV      = 3'h3;
    localparam logic [2:0]  PAR_CTR     = 3'h4;
    localparam logic [2:0]  PAR_DLY     = 3'h5;
    localparam logic [13:0] PF_DEF      = 14'h0064;
    localparam logic [13:0] PF_IND_MIN  = 14'h0046;
    localparam logic [13:0] PF_CAP_MIN  = 14'h0050;
    localparam logic [13:0] THD_MIN     = 14'h0014;
    localparam logic [13:0] THD_MAX     = 14'h01C2;
    localparam logic [13:0] THD_DEF_0   = 14'h001E;
    localparam logic [13:0] THD_DEF_1   = 14'h0046;
    localparam logic [13:0] THD_DEF_2   = 14'h005A;
    localparam logic [13:0] RATIO_MIN   = 14'h0001;
    localparam logic [13:0] RATIO_MAX   = 14'h270F;
    localparam logic [13:0] UV_DEF      = 14'h0058;
    localparam logic [13:0] UV_MIN      = 14'h0055;
    localparam logic [13:0] UV_MAX      = 14'h005F;
    localparam logic [13:0] DLY_DEF     = 14'h01F4;
    localparam logic [13:0] DLY_MAX     = 14'h07D0;

    typedef enum logic [1:0] {VIEW_LIVE, VIEW_PARAM, VIEW_EDIT} fpled_view_t;

    typedef struct packed {
        logic [3:0]        ksync1;
        logic [3:0]        ksync2;
        logic [3:0]        kprev;
        logic [1:0]        boot_sync;
        logic [1:0]        init_cnt;
        logic [3:0]        cursor;
        fpled_view_t       view;
        logic [5:0][13:0]  par;
        logic              pf_cap;
        logic              ctr_set;
        logic [27:0]       alm_new;
        logic [27:0]       alm_bg;
        logic [24:0]       tick_cnt;
        logic [2:0]        blink;
        logic [4:0]        refuse_cnt;
        logic [2:0]        refuse_step;
        logic              sw_pending;
        logic [39:0]       sw_cnt;
        logic              sw_suppr;
        logic [12:0]       rib_led;
        logic [7:0]        step_green;
        logic [7:0]        step_red;
        logic [4:0]        disp_alarm;
        logic              disp_alarm_valid;
        logic              marker;
        logic              bg_show;
        logic              sw_show;
        logic [13:0]       par_value;
        logic              par_cap;
        logic              reading_raw;
        logic              reading_blank;
    } fpled_state_t;

endpackage

/* core/fpled_panel.sv */
`timescale 1ns/100ps

// Summary of operation
// [R01] down-arrow moves ribbon cursor one LED downward, wrapping bottom to top
// [R02] cursor skips red alarm LEDs that are dark
// [R03] cursor LED lit or flashes 2.5 Hz; 1.25 Hz blink kept for status
// [R04] right-arrow on a green LED toggles live reading and blinking parameter view
// [R05] in parameter view SET opens edit, SET commits, ESC discards
// [R06] right-arrow or ESC in parameter view returns to live reading
// [R07] target power factor defaults 1.00, ind 0.70 to cap 0.80
// [R08] distortion threshold zero or 2.0 to 45.0 percent, default by detuning
// [R09] voltage parameter: ratio 1..9999 commissioning, else undervoltage 85..95 default 88
// [R10] current parameter: ratio 1..9999 commissioning, else delay 0..20 s default 5
// [R11] without current ratio, current and missing power readings blink, two decimals
// [R12] service LED blinks when cursor in tree, steady when on the ribbon
// [R13] manual LED blinks while manual mode holds regulation
// [R14] new alarm lights its group LED; cursor there shows top new alarm
// [R15] important alarms stay latched until acknowledged
// [R16] acknowledge: present alarm to background, absent cleared, next alarm shown
// [R17] SET on power factor LED acknowledges alarms of unlit groups
// [R18] software fault shown from reset until a quarter hour has passed, one ribbon loop suppresses
// [R19] red alarm LEDs never blink; step switch-off shown by marker at times
// [R20] eight two-colour step positions, never both colours, green shows step state
// [R21] step red: steady off and out of service, 1.25 Hz faulty, 2.5 Hz selected
// [R22] refused command on cursor step flashes red at 5 Hz for seconds
// [R23] 5, 2.5 and 1.25 Hz come from one binary divider chain
module fpled_panel #(
    parameter int     TICK_CYC     = fpled_pkg::TICK_CYC,
    parameter int     REFUSE_TICKS = fpled_pkg::REFUSE_TICKS,
    parameter longint SW_FAULT_CYC = fpled_pkg::SW_FAULT_CYC
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        key_down,
    input  wire logic        key_right,
    input  wire logic        key_set,
    input  wire logic        key_esc,
    input  wire logic        sw_fault_boot,
    input  wire logic        commissioning,
    input  wire logic [1:0]  detuning_sel,
    input  wire logic        in_info_tree,
    input  wire logic        in_set_tree,
    input  wire logic        manual_active,
    input  wire logic [13:0] edit_value,
    input  wire logic        edit_cap,
    input  wire logic [27:0] alarm_cause,
    input  wire logic [27:0] alarm_important,
    input  wire logic [27:0] alarm_switch_off,
    input  wire logic        restore_acknowledged_alarms_item,
    input  wire logic [7:0]  step_on,
    input  wire logic [7:0]  step_out_of_service,
    input  wire logic [7:0]  step_faulty,
    input  wire logic [7:0]  step_under_test,
    input  wire logic        step_cursor_valid,
    input  wire logic [2:0]  step_cursor,
    input  wire logic        step_refused,
    output logic      [12:0] ribbon_led,
    output logic      [7:0]  step_green,
    output logic      [7:0]  step_red,
    output logic      [4:0]  disp_alarm,
    output logic             disp_alarm_valid,
    output logic             all_steps_off_marker,
    output logic             background_alarm_show,
    output logic             software_fault_alarm,
    output logic      [13:0] param_value,
    output logic             param_cap,
    output logic      [1:0]  view_mode,
    output logic             reading_raw,
    output logic             reading_blank
);

    if (TICK_CYC < 2 || TICK_CYC > 33554432 || REFUSE_TICKS < 1 || REFUSE_TICKS > 31
        || SW_FAULT_CYC < 2 || SW_FAULT_CYC > 64'h0000_00FF_FFFF_FFFF) begin : g_chk
        $error("fpled_panel: parameter out of range");
    end

    localparam logic [24:0] TICK_LAST = 25'(TICK_CYC - 1);
    localparam logic [4:0]  REFUSE_LD = 5'(REFUSE_TICKS);
    localparam logic [39:0] SW_LAST   = 40'(SW_FAULT_CYC - 1);

    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic [3:0] next_pos(input logic [3:0] cur, input logic [4:0] red_lit);
        logic [3:0] p;
        logic       done;
        p    = cur;
        done = 1'b0;
        for (int i = 0; i < fpled_pkg::RIB_N; i++) begin
            if (!done) begin
                p = (p == fpled_pkg::POS_LAST) ? 4'h0 : p + 4'h1;
                if (p < fpled_pkg::POS_RED0 || red_lit[3'(p - fpled_pkg::POS_RED0)]) begin // [R02]
                    done = 1'b1;
                end
            end
        end
        return p;
    endfunction

    // lowest index wins: lower alarm index means higher priority
    function automatic logic [2:0] first_set(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [13:0] clamp_par(input logic [2:0] idx, input logic [13:0] v,
                                              input logic cap);
        logic [13:0] lo;
        logic [13:0] hi;
        logic [13:0] r;
        lo = fpled_pkg::RATIO_MIN;
        hi = fpled_pkg::RATIO_MAX;
        case (idx)
            fpled_pkg::PAR_PF: begin
                lo = cap ? fpled_pkg::PF_CAP_MIN : fpled_pkg::PF_IND_MIN; // [R07]
                hi = fpled_pkg::PF_DEF;
            end
            fpled_pkg::PAR_THD: begin
                lo = fpled_pkg::THD_MIN; // [R08]
                hi = fpled_pkg::THD_MAX;
            end
            fpled_pkg::PAR_UV: begin
                lo = fpled_pkg::UV_MIN; // [R09]
                hi = fpled_pkg::UV_MAX;
            end
            fpled_pkg::PAR_DLY: begin
                lo = 14'h0000; // [R10]
                hi = fpled_pkg::DLY_MAX;
            end
            default: begin
                lo = fpled_pkg::RATIO_MIN; // [R09] [R10]
                hi = fpled_pkg::RATIO_MAX;
            end
        endcase
        r = (v < lo) ? lo : (v > hi) ? hi : v;
        if (idx == fpled_pkg::PAR_THD && v == 14'h0000) begin
            r = 14'h0000; // [R08]
        end
        return r;
    endfunction

    // ==========================================================
    // state
    // ==========================================================
    fpled_pkg::fpled_state_t st;
    fpled_pkg::fpled_state_t next_st;

    logic [3:0]  press;
    logic [4:0]  red_lit;
    logic [2:0]  psel;
    logic        on_green;
    logic [27:0] ack;
    logic [2:0]  grp;
    logic [2:0]  top;
    logic [7:0]  grp_new;
    logic [7:0]  noled_new;
    logic        do_ack;
    logic        sel_s;
    logic        red_req;

    assign press = st.ksync2 & ~st.kprev;

    always_comb begin
        next_st = st;
        ack     = '0;
        do_ack  = 1'b0;
        sel_s   = 1'b0;
        red_req = 1'b0;
        grp     = 3'(st.cursor - fpled_pkg::POS_RED0);
        for (int g = 0; g < fpled_pkg::GRP_LED_N; g++) begin
            red_lit[g] = |st.alm_new[g*4 +: 4];
        end
        grp_new   = {4'h0, st.alm_new[grp*4 +: 4]};
        noled_new = st.alm_new[27:20];
        on_green  = st.cursor <= fpled_pkg::POS_CURR;
        psel      = (st.cursor == fpled_pkg::POS_PF) ? fpled_pkg::PAR_PF :
                    (st.cursor == fpled_pkg::POS_THD) ? fpled_pkg::PAR_THD :
                    (st.cursor == fpled_pkg::POS_VOLT) ?
                        (commissioning ? fpled_pkg::PAR_VTR : fpled_pkg::PAR_UV) :
                        (commissioning ? fpled_pkg::PAR_CTR : fpled_pkg::PAR_DLY);

        // key and strap synchronisers
        next_st.ksync1    = {key_esc, key_set, key_right, key_down};
        next_st.ksync2    = st.ksync1;
        next_st.kprev     = st.ksync2;
        next_st.boot_sync = {st.boot_sync[0], sw_fault_boot};

        // defaults loaded once the strap has passed both stages
        if (st.init_cnt != 2'h3) begin
            next_st.init_cnt = st.init_cnt + 2'h1;
        end
        if (st.init_cnt == fpled_pkg::INIT_LOAD) begin
            next_st.par[fpled_pkg::PAR_PF]  = fpled_pkg::PF_DEF; // [R07]
            next_st.par[fpled_pkg::PAR_THD] = (detuning_sel == 2'h0) ? fpled_pkg::THD_DEF_0 :
                                              (detuning_sel == 2'h1) ? fpled_pkg::THD_DEF_1 :
                                              fpled_pkg::THD_DEF_2; // [R08]
            next_st.par[fpled_pkg::PAR_VTR] = fpled_pkg::RATIO_MIN;
            next_st.par[fpled_pkg::PAR_UV]  = fpled_pkg::UV_DEF; // [R09]
            next_st.par[fpled_pkg::PAR_CTR] = fpled_pkg::RATIO_MIN;
            next_st.par[fpled_pkg::PAR_DLY] = fpled_pkg::DLY_DEF; // [R10]
            next_st.pf_cap     = 1'b0;
            next_st.sw_pending = st.boot_sync[1];
            next_st.sw_cnt     = '0;
        end

        // ======================================================
        // key handling: cursor, views, acknowledge
        // ======================================================
        case (st.view)
            fpled_pkg::VIEW_LIVE: begin
                if (press[0]) begin
                    next_st.cursor = next_pos(st.cursor, red_lit); // [R01]
                    if (next_pos(st.cursor, red_lit) <= st.cursor && st.sw_pending) begin
                        next_st.sw_suppr = 1'b1; // [R18]
                    end
                end else if (press[1] && on_green) begin
                    next_st.view = fpled_pkg::VIEW_PARAM; // [R04]
                end else if (press[2] && st.cursor >= fpled_pkg::POS_RED0
                             && |grp_new) begin
                    ack[{grp, 2'h0} + 5'(first_set(grp_new))] = 1'b1; // [R16]
                    do_ack = 1'b1;
                end else if (press[2] && st.cursor == fpled_pkg::POS_PF && |noled_new) begin
                    ack[5'd20 + 5'(first_set(noled_new))] = 1'b1; // [R17]
                    do_ack = 1'b1;
                end
            end
            fpled_pkg::VIEW_PARAM: begin
                if (press[1] || press[3]) begin
                    next_st.view = fpled_pkg::VIEW_LIVE; // [R06]
                end else if (press[2]) begin
                    next_st.view = fpled_pkg::VIEW_EDIT; // [R05]
                end
            end
            fpled_pkg::VIEW_EDIT: begin
                if (press[2]) begin
                    next_st.par[psel] = clamp_par(psel, edit_value, edit_cap); // [R05]
                    if (psel == fpled_pkg::PAR_PF) begin
                        next_st.pf_cap = edit_cap & (edit_value < fpled_pkg::PF_DEF); // [R07]
                    end
                    if (psel == fpled_pkg::PAR_CTR) begin
                        next_st.ctr_set = 1'b1; // [R11]
                    end
                    next_st.view = fpled_pkg::VIEW_PARAM;
                end else if (press[3]) begin
                    next_st.view = fpled_pkg::VIEW_PARAM; // [R05]
                end
            end
            default: next_st.view = fpled_pkg::VIEW_LIVE;
        endcase

        // ======================================================
        // alarms: latch, acknowledge, background, restore
        // ======================================================
        for (int i = 0; i < fpled_pkg::ALM_N; i++) begin
            next_st.alm_new[i] = (((st.alm_new[i] & (alarm_cause[i] | alarm_important[i]))
                                  | (alarm_cause[i] & ~st.alm_bg[i])) & ~ack[i])
                                 | (restore_acknowledged_alarms_item & st.alm_bg[i]); // [R15]
            next_st.alm_bg[i]  = (st.alm_bg[i] | ack[i]) & alarm_cause[i]
                                 & ~restore_acknowledged_alarms_item; // [R16]
        end

        // ======================================================
        // blink divider, refuse flash, software fault window
        // ======================================================
        next_st.tick_cnt = (st.tick_cnt == TICK_LAST) ? '0 : st.tick_cnt + 25'h000_0001;
        if (st.tick_cnt == TICK_LAST) begin
            next_st.blink = st.blink + 3'h1; // [R23]
            if (st.refuse_cnt != 5'h00) begin
                next_st.refuse_cnt = st.refuse_cnt - 5'h01;
            end
        end
        if (step_refused && step_cursor_valid) begin
            next_st.refuse_cnt  = REFUSE_LD; // [R22]
            next_st.refuse_step = step_cursor;
        end
        if (st.sw_pending && st.init_cnt == 2'h3) begin
            next_st.sw_cnt = st.sw_cnt + 40'h00_0000_0001;
            if (st.sw_cnt == SW_LAST) begin
                next_st.sw_pending = 1'b0; // [R18]
            end
        end

        // ======================================================
        // outputs
        // ======================================================
        for (int p = 0; p < fpled_pkg::RIB_N; p++) begin
            next_st.rib_led[p] = 1'b0;
        end
        next_st.rib_led[fpled_pkg::POS_INFO] = in_info_tree & st.blink[2]; // [R12]
        next_st.rib_led[fpled_pkg::POS_SET]  = in_set_tree & st.blink[2]; // [R12]
        next_st.rib_led[fpled_pkg::POS_MAN]  = manual_active & st.blink[2]; // [R13]
        for (int g = 0; g < fpled_pkg::GRP_LED_N; g++) begin
            next_st.rib_led[8 + g] = red_lit[g]; // [R14] [R19]
        end
        // cursor LED: steady on the ribbon, fast flash while a parameter is shown
        next_st.rib_led[st.cursor] = (st.view == fpled_pkg::VIEW_LIVE) ? 1'b1 : st.blink[1]; // [R03] [R04] [R12]

        for (int s = 0; s < fpled_pkg::STEP_N; s++) begin
            sel_s = step_cursor_valid && step_cursor == 3'(s);
            if (st.refuse_cnt != 5'h00 && st.refuse_step == 3'(s)) begin
                red_req = st.blink[0]; // [R22]
            end else if (sel_s) begin
                red_req = st.blink[1]; // [R21]
            end else if (step_faulty[s] || step_under_test[s]) begin
                red_req = st.blink[2]; // [R21]
            end else begin
                red_req = ~step_on[s] & step_out_of_service[s]; // [R21]
            end
            // red phases blank green so both never light together
            next_st.step_red[s]   = red_req; // [R20]
            next_st.step_green[s] = step_on[s] & ~red_req; // [R20]
        end

        top = first_set(grp_new);
        if (st.cursor >= fpled_pkg::POS_RED0 && |grp_new) begin
            next_st.disp_alarm       = {grp, 2'h0} + 5'(top); // [R14]
            next_st.disp_alarm_valid = 1'b1;
        end else if (|noled_new) begin
            next_st.disp_alarm       = 5'd20 + 5'(first_set(noled_new));
            next_st.disp_alarm_valid = 1'b1;
        end else begin
            next_st.disp_alarm       = 5'h00;
            next_st.disp_alarm_valid = 1'b0;
        end
        next_st.marker  = |((st.alm_new | st.alm_bg) & alarm_switch_off) & st.blink[2]; // [R19]
        next_st.bg_show = |st.alm_bg & ~st.blink[2]; // [R16]
        next_st.sw_show = st.sw_pending & ~st.sw_suppr & (st.init_cnt == 2'h3); // [R18]

        if (st.view == fpled_pkg::VIEW_EDIT) begin
            next_st.par_value = clamp_par(psel, edit_value, edit_cap);
            next_st.par_cap   = edit_cap;
        end else begin
            next_st.par_value = st.par[psel];
            next_st.par_cap   = (psel == fpled_pkg::PAR_PF) & st.pf_cap;
        end
        next_st.reading_raw   = ~st.ctr_set & (st.cursor == fpled_pkg::POS_CURR
                                               || st.cursor == fpled_pkg::POS_MISSQ); // [R11]
        next_st.reading_blank = next_st.reading_raw & st.blink[1]; // [R11]
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ribbon_led            = st.rib_led;
    assign step_green            = st.step_green;
    assign step_red              = st.step_red;
    assign disp_alarm            = st.disp_alarm;
    assign disp_alarm_valid      = st.disp_alarm_valid;
    assign all_steps_off_marker  = st.marker;
    assign background_alarm_show = st.bg_show;
    assign software_fault_alarm  = st.sw_show;
    assign param_value           = st.par_value;
    assign param_cap             = st.par_cap;
    assign view_mode             = st.view;
    assign reading_raw           = st.reading_raw;
    assign reading_blank         = st.reading_blank;

endmodule

/* dv/fpled_panel_properties.sv */
`timescale 1ns/100ps
// ====================
// panel port checks
module fpled_panel_properties (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        key_down,
    input wire logic        key_right,
    input wire logic        key_set,
    input wire logic        key_esc,
    input wire logic [27:0] alarm_cause,
    input wire logic [7:0]  step_on,
    input wire logic [7:0]  step_green,
    input wire logic [7:0]  step_red,
    input wire logic [12:0] ribbon_led,
    input wire logic [1:0]  view_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_set;
        $rose(key_set) && !key_down && !key_right && !key_esc;
    endsequence
    sequence s_back;
        ($rose(key_right) || $rose(key_esc)) && !key_down && !key_set;
    endsequence
    AST_STEP_EXCL: assert property ((step_green & step_red) == 8'h00)
        else $error("step colours lit together");
    AST_GREEN_STATE: assert property (!$past(sys_rst) && $stable(step_on)
        |-> step_green == (step_on & ~step_red)) else $error("green not step state");
    AST_SET_EDIT: assert property (s_set ##0 view_mode == 2'h1 |-> ##3 view_mode == 2'h2)
        else $error("set did not open edit");
    AST_EDIT_DONE: assert property ((s_set or s_back) ##0 view_mode == 2'h2 && !key_right
        |-> ##3 view_mode == 2'h1) else $error("edit not closed");
    AST_PARAM_BACK: assert property (s_back ##0 view_mode == 2'h1 |-> ##3 view_mode == 2'h0)
        else $error("no return to reading");
    AST_VIEW_CAUSE: assert property ($changed(view_mode)
        |-> $past(key_right, 3) || $past(key_set, 3) || $past(key_esc, 3))
        else $error("view changed without key");
    AST_EDIT_FROM_PARAM: assert property (view_mode == 2'h2 && $past(view_mode) != 2'h2
        |-> $past(view_mode) == 2'h1) else $error("edit entered from wrong view");
    AST_ALARM_LIGHT: assert property ($rose(alarm_cause[0]) |-> ##2 ribbon_led[8])
        else $error("new alarm led dark");
    AST_LED_CAUSE: assert property ($rose(ribbon_led[8])
        |-> |($past(alarm_cause, 2) & 28'h000_000F)) else $error("alarm led lit without cause");
endmodule

bind fpled_panel fpled_panel_properties i_props (.clk, .sys_rst, .key_down, .key_right,
    .key_set, .key_esc, .alarm_cause, .step_on, .step_green, .step_red, .ribbon_led,
    .view_mode);

/* dv/fpled_keypad.sv */
`timescale 1ns/100ps
// ====================
// operator keypad
module fpled_keypad (
    input  wire logic       clk,
    input  wire logic [3:0] press,
    output logic      [3:0] keys
);
    logic [3:0] held = 4'h0;
    // two-cycle hold so the two-flop sync cannot miss a stroke
    always @(posedge clk) begin
        keys <= #1 press | held;
        held <= #1 press;
    end
endmodule

/* dv/tb_top.sv */
`timescale 1ns/100ps
// ====================
// panel bench
module tb_top;
    logic        clk = 1'h0, sys_rst = 1'h1, key_down, key_right, key_set, key_esc;
    logic        sw_fault_boot = 1'h1, commissioning = 1'h0, in_info_tree = 1'h0;
    logic        in_set_tree = 1'h0, manual_active = 1'h0, edit_cap = 1'h0;
    logic        restore_acknowledged_alarms_item = 1'h0, step_cursor_valid = 1'h0;
    logic        step_refused = 1'h0, disp_alarm_valid, all_steps_off_marker, param_cap;
    logic        background_alarm_show, software_fault_alarm, reading_raw, reading_blank;
    logic [1:0]  detuning_sel = 2'h0, view_mode;
    logic [2:0]  step_cursor = 3'h2;
    logic [3:0]  press = 4'h0;
    logic [4:0]  disp_alarm;
    logic [7:0]  step_on = 8'h00, step_out_of_service = 8'h00, step_faulty = 8'h00;
    logic [7:0]  step_under_test = 8'h00, step_green, step_red;
    logic [12:0] ribbon_led;
    logic [13:0] edit_value = 14'h0000, param_value;
    logic [27:0] alarm_cause = 28'h000_0000, alarm_important = 28'h000_0000;
    logic [27:0] alarm_switch_off = 28'h000_0000;
    int          bad_count = 0, samples_checked = 0, n [8];
    always #2.5 clk = ~clk;
    wire [5:0]   blinks = {all_steps_off_marker, background_alarm_show, ribbon_led[6:5],
        step_red[2], step_red[0]};
    fpled_keypad i_keys (.clk, .press, .keys({key_down, key_right, key_set, key_esc}));
    fpled_panel #(.TICK_CYC(4), .REFUSE_TICKS(3), .SW_FAULT_CYC(1000)) i_dut (.*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // 3 down, 2 right, 1 set, 0 esc; outputs settle two edges after sync
    task automatic key(input int k);
        press[k] = 1'h1;
        tick(1);
        press = 4'h0;
        tick(8);
    endtask
    // counts level changes of blinking outputs, one sample per cycle
    task automatic watch(input int c);
        logic [5:0] p, d;
        n = '{default: 0};
        p = blinks;
        repeat (c) begin
            tick(1);
            d = p ^ blinks;
            p = d ^ p;
            for (int i = 0; i < 6; i++)
                n[i] += int'(d[i]);
            n[6] += int'(d[0] & ~d[1]);
            n[7] += int'(!step_red[4]);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        bad_count++;
        print_verdict();
    end
    initial begin
        tick(4);
        sys_rst = 1'h0;
        tick(6);
        chk(software_fault_alarm, 1'h1);
        chk(ribbon_led[0], 1'h1);
        key(2);
        chk(param_value, 14'h0064);
        edit_value = 14'h0200;
        key(1);
        chk(param_value, 14'h0064);
        edit_value = 14'h0030;
        tick(4);
        chk(param_value, 14'h0046);
        key(1);
        chk(view_mode, 2'h1);
        edit_cap = 1'h1;
        edit_value = 14'h0010;
        key(1);
        chk({param_cap, param_value}, 15'h4050);
        key(0);
        chk(param_value, 14'h0046);
        key(0);
        chk(view_mode, 2'h0);
        $display("test parameter_edit done");
        alarm_cause = 28'h000_0003;
        key(3);
        chk(ribbon_led[1], 1'h1);
        chk(ribbon_led[8], 1'h1);
        chk(param_value, 14'h001E);
        key(3);
        key(2);
        chk(param_value, 14'h0058);
        key(2);
        key(3);
        chk(param_value, 14'h01F4);
        chk({reading_raw, reading_blank}, 2'h3);
        repeat (5) key(3);
        chk({disp_alarm_valid, disp_alarm}, 6'h20);
        key(1);
        chk(disp_alarm, 5'h01);
        key(3);
        chk(ribbon_led[0], 1'h1);
        alarm_cause = 28'h000_0010;
        alarm_important = 28'h000_0010;
        tick(2);
        alarm_cause = 28'h000_0000;
        tick(8);
        chk(ribbon_led[9:8], 2'h2);
        chk(software_fault_alarm, 1'h0);
        alarm_cause = 28'h010_0000;
        key(1);
        chk(disp_alarm_valid, 1'h0);
        $display("test alarms done");
        step_on = 8'h03;
        alarm_switch_off = 28'h000_0010;
        step_faulty = 8'h01;
        step_out_of_service = 8'h10;
        manual_active = 1'h1;
        in_info_tree = 1'h1;
        step_cursor_valid = 1'h1;
        step_refused = 1'h1;
        tick(1);
        step_refused = 1'h0;
        tick(1);
        watch(8);
        chk(n[1] >= 2, 1'h1);
        tick(20);
        watch(64);
        chk(n[0], 4);
        chk(n[1], 8);
        chk(n[4], 4);
        chk(n[5], 4);
        chk(n[6], 0);
        chk(n[7], 0);
        chk(n[2] >= 2 && n[3] >= 2, 1'h1);
        chk(step_green[1], 1'h1);
        $display("test steps done");
        print_verdict();
    end
endmodule
